// *** common/sssc_defs.vh ***
`ifndef SSSC_DEFS_VH
`define SSSC_DEFS_VH
// setpoint and output values: signed tenths of a percent, 16 bits
`define SSSC_VAL_W 16
`define SSSC_VAL_MIN 16'shFF06
`define SSSC_VAL_MAX 16'sh04E2
`define SSSC_VAL_RST 16'sh0000
`define SSSC_OUT_OFF 16'shFF06
`define SSSC_CONTROL_TEMPLATE_SEL_A 8'h33
`define SSSC_CONTROL_TEMPLATE_SEL_B 8'h36
`define SSSC_CYCLE_NS 50000000
`define SSSC_CLK_NS 50
`define SSSC_CYCLE_CNT (`SSSC_CYCLE_NS / `SSSC_CLK_NS)
`define SSSC_DISP_ON 1'b0
`endif

// *** hw/sssc_clamp.v ***
`timescale 1ns/10ps
`include "sssc_defs.vh"
module sssc_clamp (
  din,
  lim_en,
  lim_lo,
  lim_hi,
  dout
);
  input wire signed [15:0] din;
  input wire lim_en;
  input wire signed [15:0] lim_lo;
  input wire signed [15:0] lim_hi;
  output reg signed [15:0] dout;
  reg signed [15:0] t;
  always @* begin
    t = din;
    if (t < `SSSC_VAL_MIN) begin
      t = `SSSC_VAL_MIN;
    end
    if (t > `SSSC_VAL_MAX) begin
      t = `SSSC_VAL_MAX;
    end
    if (lim_en && t < lim_lo) begin
      t = lim_lo;
    end
    if (lim_en && t > lim_hi) begin
      t = lim_hi;
    end
    dout = t;
  end
endmodule // sssc_clamp

// *** hw/sssc_sync2.v ***
`timescale 1ns/10ps
module sssc_sync2 #(
  parameter W = 1
) (
  mclk,
  d,
  q
);
  input wire mclk;
  input wire [W-1:0] d;
  output reg [W-1:0] q;
  reg [W-1:0] meta_r;
  always @(posedge mclk) begin
    meta_r <= d;
    q <= meta_r;
  end
endmodule // sssc_sync2

// *** hw/sssc_top.v ***
// How it works
// R1: selection only with template 51 or 54
// R2: three inputs form binary setpoint index
// R3: index one to seven means remote mode
// R4: setpoints clamped to range and limiter
// R5: standby request switches run and standby
// R6: standby turns other outputs off
// R7: standby indicator lit during standby
// R8: standby outputs use heat/cool standby values
// R9: leaving standby resumes from heat value
// R10: communication and control mode unaffected
// R11: edge inputs ignore levels at return
// R12: standby request kept non-volatile
// R13: standby aborts tuning, keeps constants
// R14: display option blanks or keeps display
// R15: other templates use local setpoint
// R16: inputs sampled once per control cycle
`timescale 1ns/10ps
`include "sssc_defs.vh"
module sssc_top #(
  parameter CYCLE_CNT = `SSSC_CYCLE_CNT
) (
  mclk,
  sys_rst,
  control_template,
  setpoint_select_bit0,
  setpoint_select_bit1,
  setpoint_select_bit2,
  local_setpoint,
  stored_setpoints,
  sp_limit_en,
  sp_limit_lo,
  sp_limit_hi,
  standby_request_nv,
  standby_display_option,
  heat_standby_output,
  cool_standby_output,
  heat_computed,
  cool_computed,
  aux_outputs_in,
  edge_inputs_in,
  tuning_active,
  target_setpoint,
  remote_mode,
  control_output_heat,
  control_output_cool,
  aux_outputs,
  analog_retrans_off,
  standby_indicator,
  value_display_on,
  bumpless_load,
  edge_inputs_rise,
  tuning_abort,
  cycle_tick
);
  input wire mclk;
  input wire sys_rst;
  input wire [7:0] control_template;
  input wire setpoint_select_bit0;
  input wire setpoint_select_bit1;
  input wire setpoint_select_bit2;
  input wire signed [15:0] local_setpoint;
  // seven stored setpoints, setpoint n at bits 16n-1..16(n-1)
  input wire [111:0] stored_setpoints;
  input wire sp_limit_en;
  input wire signed [15:0] sp_limit_lo;
  input wire signed [15:0] sp_limit_hi;
  input wire standby_request_nv;
  input wire standby_display_option;
  input wire signed [15:0] heat_standby_output;
  input wire signed [15:0] cool_standby_output;
  input wire signed [15:0] heat_computed;
  input wire signed [15:0] cool_computed;
  input wire [7:0] aux_outputs_in;
  input wire [3:0] edge_inputs_in;
  input wire tuning_active;
  output reg signed [15:0] target_setpoint;
  output reg remote_mode;
  output reg signed [15:0] control_output_heat;
  output reg signed [15:0] control_output_cool;
  output reg [7:0] aux_outputs;
  output reg analog_retrans_off;
  output reg standby_indicator;
  output reg value_display_on;
  output reg bumpless_load;
  output reg [3:0] edge_inputs_rise;
  output reg tuning_abort;
  output reg cycle_tick;

  // ****************************************
  // input synchronisation and control cycle
  // ****************************************
  wire [2:0] sel_sync;
  wire standby_indicator_sync;
  wire [3:0] edge_sync;
  sssc_sync2 #(.W(8)) u_sync (
    .mclk(mclk),
    .d({edge_inputs_in, standby_request_nv, setpoint_select_bit2,
        setpoint_select_bit1, setpoint_select_bit0}),
    .q({edge_sync, standby_indicator_sync, sel_sync})
  );

  reg [31:0] cyc_cnt_r;
  wire tick = (cyc_cnt_r == CYCLE_CNT - 1);
  always @(posedge mclk) begin
    if (sys_rst) begin
      cyc_cnt_r <= 32'h00000000;
    end else if (tick) begin
      cyc_cnt_r <= 32'h00000000;
    end else begin
      cyc_cnt_r <= cyc_cnt_r + 32'h00000001;
    end
  end

  // ****************************************
  // setpoint selection
  // ****************************************
  // R1: template gate
  wire control_template_ok = (control_template == `SSSC_CONTROL_TEMPLATE_SEL_A) ||
                 (control_template == `SSSC_CONTROL_TEMPLATE_SEL_B);
  reg [2:0] sel_r;
  reg standby_indicator_r;
  reg [3:0] edge_prev_r;
  // R15: other templates force local
  // R2: binary code, bit0 weight 1
  wire [2:0] sel_idx = control_template_ok ? sel_sync : 3'h0;
  // stored setpoints unpacked one by one
  wire signed [15:0] sp1 = stored_setpoints[15:0];
  wire signed [15:0] sp2 = stored_setpoints[31:16];
  wire signed [15:0] sp3 = stored_setpoints[47:32];
  wire signed [15:0] sp4 = stored_setpoints[63:48];
  wire signed [15:0] sp5 = stored_setpoints[79:64];
  wire signed [15:0] sp6 = stored_setpoints[95:80];
  wire signed [15:0] sp7 = stored_setpoints[111:96];
  reg signed [15:0] raw_sp;
  always @* begin
    raw_sp = local_setpoint;
    case (sel_r)
      3'h1: raw_sp = sp1;
      3'h2: raw_sp = sp2;
      3'h3: raw_sp = sp3;
      3'h4: raw_sp = sp4;
      3'h5: raw_sp = sp5;
      3'h6: raw_sp = sp6;
      3'h7: raw_sp = sp7;
      default: raw_sp = local_setpoint;
    endcase
  end
  wire signed [15:0] sp_clamped;
  // R4: range and limiter clamp
  sssc_clamp u_sp_clamp (
    .din(raw_sp),
    .lim_en(sp_limit_en),
    .lim_lo(sp_limit_lo),
    .lim_hi(sp_limit_hi),
    .dout(sp_clamped)
  );
  wire signed [15:0] heat_sb;
  wire signed [15:0] cool_sb;
  // R8: standby values kept in range
  sssc_clamp u_heat_clamp (
    .din(heat_standby_output),
    .lim_en(1'b0),
    .lim_lo(`SSSC_VAL_MIN),
    .lim_hi(`SSSC_VAL_MAX),
    .dout(heat_sb)
  );
  sssc_clamp u_cool_clamp (
    .din(cool_standby_output),
    .lim_en(1'b0),
    .lim_lo(`SSSC_VAL_MIN),
    .lim_hi(`SSSC_VAL_MAX),
    .dout(cool_sb)
  );

  // ****************************************
  // per cycle state
  // ****************************************
  // R16: sample once per control cycle
  always @(posedge mclk) begin
    if (sys_rst) begin
      cycle_tick <= 1'b0;
    end else begin
      cycle_tick <= tick;
    end
  end

  // R10: setpoint path runs in standby
  always @(posedge mclk) begin
    if (sys_rst) begin
      sel_r <= 3'h0;
      target_setpoint <= `SSSC_VAL_RST;
      remote_mode <= 1'b0;
    end else if (tick) begin
      sel_r <= sel_idx;
      target_setpoint <= sp_clamped;
      // R3: stored setpoint means remote
      remote_mode <= (sel_r != 3'h0);
    end
  end

  // R5: run/standby follows request
  // R12: request comes from retained storage; reset clears the state to run and the first tick loads the request
  always @(posedge mclk) begin
    if (sys_rst) begin
      standby_indicator_r <= 1'b0;
      standby_indicator <= 1'b0;
    end else if (tick) begin
      standby_indicator_r <= standby_indicator_sync;
      // R7: indicator tracks standby
      standby_indicator <= standby_indicator_sync;
    end
  end

  // one mclk pulses, raised only on a tick
  always @(posedge mclk) begin
    if (sys_rst) begin
      bumpless_load <= 1'b0;
      tuning_abort <= 1'b0;
    end else begin
      // R13: abort tuning on entry
      tuning_abort <= tick && standby_indicator_sync && !standby_indicator_r && tuning_active;
      // R9: resume from heat standby value
      bumpless_load <= tick && standby_indicator_r && !standby_indicator_sync;
    end
  end

  // R11: edge inputs tracked through standby
  // levels held through standby are absorbed, so they cannot fire later
  always @(posedge mclk) begin
    if (sys_rst) begin
      edge_prev_r <= 4'h0;
      edge_inputs_rise <= 4'h0;
    end else begin
      edge_inputs_rise <= 4'h0;
      if (tick) begin
        edge_prev_r <= edge_sync;
        if (!standby_indicator_sync) begin
          edge_inputs_rise <= edge_sync & ~edge_prev_r;
        end
      end
    end
  end

  // control and other outputs
  always @(posedge mclk) begin
    if (sys_rst) begin
      control_output_heat <= `SSSC_OUT_OFF;
      control_output_cool <= `SSSC_OUT_OFF;
      aux_outputs <= 8'h00;
      analog_retrans_off <= 1'b0;
      value_display_on <= 1'b1;
    end else begin
      if (tick) begin
        if (standby_indicator_sync) begin
          // R6: other outputs off
          // R8: standby output values
          control_output_heat <= heat_sb;
          control_output_cool <= cool_sb;
          aux_outputs <= 8'h00;
          analog_retrans_off <= 1'b1;
          // R14: display option
          value_display_on <= (standby_display_option == `SSSC_DISP_ON);
        end else begin
          control_output_heat <= standby_indicator_r ? heat_sb : heat_computed;
          control_output_cool <= standby_indicator_r ? cool_sb : cool_computed;
          aux_outputs <= aux_outputs_in;
          analog_retrans_off <= 1'b0;
          value_display_on <= 1'b1;
        end
      end
    end
  end
endmodule // sssc_top

// *** tb/setpoint_select_standby_ctrl_tb_top.sv ***
`timescale 1ns/10ps
`include "sssc_defs.vh"
// **
// bench top
// **
module setpoint_select_standby_ctrl_tb_top;
  reg mclk = 1'b0, sys_rst = 1'b1, sp_limit_en = 1'b0, tuning_active = 1'b0;
  reg standby_request_nv = 1'b0, standby_display_option = 1'b0;
  reg seen_rise = 1'b0, seen_abort = 1'b0;
  reg [2:0] code = 3'h0;
  reg [3:0] ev = 4'h0;
  reg [7:0] control_template = 8'h33, aux_outputs_in = 8'hA5;
  reg [15:0] local_setpoint = 16'h0000, heat_computed = 16'h0000;
  reg [15:0] sp_limit_lo = 16'hFF06, sp_limit_hi = 16'h04E2;
  reg [15:0] heat_standby_output = 16'h0190;
  reg [15:0] cool_standby_output = 16'hFF9C;
  reg [111:0] stored_setpoints = 112'h0;
  reg [31:0] rs = 32'h00000038;
  wire [15:0] cool_computed = heat_computed;
  wire [15:0] target_setpoint, control_output_heat, control_output_cool;
  wire [7:0] aux_outputs;
  wire [3:0] edge_inputs_in, edge_inputs_rise;
  wire setpoint_select_bit0, setpoint_select_bit1, setpoint_select_bit2;
  wire remote_mode, analog_retrans_off, standby_indicator, value_display_on;
  wire bumpless_load, tuning_abort, cycle_tick;
  wire tpl_ok = control_template == `SSSC_CONTROL_TEMPLATE_SEL_A ||
    control_template == `SSSC_CONTROL_TEMPLATE_SEL_B;
  integer n_mismatch = 0, n_compared = 0, i, t;
  sssc_top #(.CYCLE_CNT(8)) i_dut (.*);
  sssc_contacts i_far (.mclk, .lvl({ev, code}), .pins({edge_inputs_in,
    setpoint_select_bit2, setpoint_select_bit1, setpoint_select_bit0}));
  initial forever #25 mclk = ~mclk;
  always @(posedge mclk) begin
    if (edge_inputs_rise != 4'h0) seen_rise <= 1'b1;
    if (tuning_abort) seen_abort <= 1'b1;
  end
  function [31:0] xs(input [31:0] v);
    begin
      v = v ^ (v << 13);
      v = v ^ (v >> 17);
      xs = v ^ (v << 5);
    end
  endfunction
  // values above full range come back clamped
  function [15:0] exp_sp(input [2:0] c);
    begin
      exp_sp = local_setpoint;
      if (tpl_ok && c != 3'h0) exp_sp = stored_setpoints[c*16-16 +: 16];
      if ($signed(exp_sp) > $signed(`SSSC_VAL_MAX)) exp_sp = `SSSC_VAL_MAX;
    end
  endfunction
  task chk(input [63:0] nm, input [15:0] seen, input [15:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("unexpected %0s exp %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task tk(input integer n);
    begin
      repeat (n) @(posedge cycle_tick);
      @(negedge mclk);
    end
  endtask
  task end_sim;
    begin
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  initial begin
    #100000;
    n_mismatch = n_mismatch + 1;
    end_sim;
  end
  initial begin
    for (i = 0; i < 7; i = i + 1) begin
      rs = xs(rs);
      stored_setpoints[i*16 +: 16] = {5'h00, rs[10:0] % 11'h5DD} - 16'h00FA;
    end
    stored_setpoints[111:96] = 16'h7FFF;
    local_setpoint = {6'h00, rs[25:16]};
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    sys_rst <= 1'b0;
    for (t = 0; t < 3; t = t + 1) begin
      for (i = 0; i < 8; i = i + 1) begin
        control_template <= (t == 2) ? 8'h32 : (t == 1) ? 8'h36 : 8'h33;
        code <= i[2:0];
        // two sync flops plus two ticks of lag (sel_r, then target_setpoint): three ticks cover it
        tk(3);
        chk("sp", target_setpoint, exp_sp(code));
        chk("remote", remote_mode, tpl_ok && code != 3'h0);
      end
    end
    $display("test selection done");
    tuning_active <= 1'b1;
    standby_display_option <= 1'b1;
    standby_request_nv <= 1'b1;
    tk(3);
    ev <= 4'hF;
    tk(2);
    chk("standby_indicator", standby_indicator, 1'b1);
    chk("cool", control_output_cool, cool_standby_output);
    chk("disp", value_display_on, 1'b0);
    chk("abort", seen_abort, 1'b1);
    chk("aux", aux_outputs, 8'h00);
    chk("retr", analog_retrans_off, 1'b1);
    heat_computed <= 16'h0300;
    tuning_active <= 1'b0;
    standby_request_nv <= 1'b0;
    tk(4);
    chk("heat", control_output_heat, heat_computed);
    chk("disp", value_display_on, 1'b1);
    chk("rise", seen_rise, 1'b0);
    chk("aux", aux_outputs, aux_outputs_in);
    chk("retr", analog_retrans_off, 1'b0);
    chk("cool", control_output_cool, cool_computed);
    ev <= 4'h0;
    tk(2);
    ev <= 4'hF;
    tk(2);
    chk("rise", seen_rise, 1'b1);
    $display("test standby done");
    end_sim;
  end
endmodule // setpoint_select_standby_ctrl_tb_top
bind sssc_top sssc_checker #(.CYCLE_CNT(CYCLE_CNT)) i_chk (.*);

// *** tb/sssc_checker.sv ***
`timescale 1ns/10ps
// **
// port checks
// **
module sssc_checker #(
  parameter CYCLE_CNT = 8
) (
  input wire mclk,
  input wire sys_rst,
  input wire cycle_tick,
  input wire standby_indicator,
  input wire value_display_on,
  input wire bumpless_load,
  input wire tuning_abort,
  input wire [7:0] aux_outputs,
  input wire signed [15:0] heat_standby_output,
  input wire signed [15:0] control_output_heat,
  input wire signed [15:0] target_setpoint
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // seven idle cycles hold only for the bench value CYCLE_CNT of 8
  tick_gap_a:
    assert property (cycle_tick |=> (!cycle_tick) [*7] ##1 cycle_tick)
    else $error("tick spacing wrong");
  hold_out_a:
    assert property (!cycle_tick |-> $stable(target_setpoint) &&
      $stable(standby_indicator)) else $error("output moved off tick");
  sp_range_a:
    assert property (target_setpoint >= 16'shFF06 &&
      target_setpoint <= 16'sh04E2) else $error("setpoint out of range");
  aux_off_a:
    assert property (standby_indicator |-> aux_outputs == 8'h00)
    else $error("aux on in standby");
  heat_sby_a:
    assert property (standby_indicator |->
      control_output_heat == heat_standby_output) else $error("heat wrong");
  bump_start_a:
    assert property ($fell(standby_indicator) && !$past(sys_rst) |->
      bumpless_load && control_output_heat == heat_standby_output)
    else $error("restart not bumpless");
  disp_run_a:
    assert property (cycle_tick && !standby_indicator |-> value_display_on)
    else $error("display off in run");
  tune_abort_a:
    assert property (tuning_abort |-> $rose(standby_indicator))
    else $error("abort without standby entry");
endmodule // sssc_checker

// *** tb/sssc_contacts.sv ***
`timescale 1ns/10ps
// **
// contact levels, switched at the falling edge
// **
module sssc_contacts (
  input wire mclk,
  input wire [6:0] lvl,
  output reg [6:0] pins = 7'h00
);
  always @(negedge mclk) pins <= lvl;
endmodule // sssc_contacts
